// [core/pfl_fault_ctrl.sv]
/*
 * Fault latching, auto-restart and turn-off style controller of a point-of-load converter.
 * Assumes fault detector levels, turn-on command and register strobes are synchronous to clk;
 * input power cycling is seen as rstn.
 */
// Overview of operation
// - non-latching fault: retry start-up every 130ms until the cause disappears
// - each restart ramps up exactly like a normal turn-on
// - latching fault: shut down and stay off, no automatic restarts
// - latched unit restarts after 130ms, cause gone, plus flag clear or command toggle
// - each protection selectable latching or not, propagating or not, writable
// - setup bit 7 enables tracking fault, resets to 0
// - setup bit 6 enables phase voltage error, resets to 1
// - setup bits 5..0 choose latching per fault; bits 1,0 reset to 1
// - overheat, undervoltage, overvoltage turn-off style individually selectable
// - sequenced turn-off ramps down like a normal controlled shutdown
// - critical turn-off switches both high and low side off at once
// - emergency turn-off: high side off and low side on together
// - a tripped protection drives its fault flag to 0
// - overcurrent and tracking faults use critical turn-off unless an emergency-style cause trips in the same cycle
`timescale 1ns/10ps
module pfl_fault_ctrl
    import pfl_pkg::*;
#(
    parameter int unsigned RESTART_CNT = RESTART_CYCLES
)
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic       turn_on_cmd,
    input  wire logic [5:0] fault_detect,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            conv_enable,
    output logic            ramp_down_req,
    output logic            hs_force_off,
    output logic            ls_force_off,
    output logic            ls_force_on,
    output logic            ok_pull_low,
    output logic      [5:0] fault_flag_register
);

    // turn-off style for a set of causes; the hardest style wins
    function automatic logic [1:0] pick_style(input logic [5:0] cause, input logic [5:0] sty);
        logic emerg;
        logic crit;
        emerg = (cause[FLT_OT] && sty[STY_OT_LSB +: 2] == STYLE_EMERG)
              || (cause[FLT_UV] && sty[STY_UV_LSB +: 2] == STYLE_EMERG)
              || (cause[FLT_OV] && sty[STY_OV_LSB +: 2] == STYLE_EMERG);
        crit  = cause[FLT_OC] || cause[FLT_TRK] || cause[FLT_PV]
              || (cause[FLT_OT] && sty[STY_OT_LSB +: 2] == STYLE_CRIT)
              || (cause[FLT_UV] && sty[STY_UV_LSB +: 2] == STYLE_CRIT)
              || (cause[FLT_OV] && sty[STY_OV_LSB +: 2] == STYLE_CRIT);
        if (emerg)
            pick_style = STYLE_EMERG;
        else if (crit)
            pick_style = STYLE_CRIT;
        else
            pick_style = STYLE_SEQ;
    endfunction

    logic [7:0]  setup_reg;
    logic [5:0]  style_reg;
    logic [5:0]  prop_reg;
    logic [5:0]  flags_reg;
    logic [5:0]  cause_reg;
    logic [1:0]  active_style_reg;
    logic        cmd_low_seen_reg;
    pfl_state_e  state_reg;
    pfl_state_e  state_next;
    logic [5:0]  enable_mask;
    logic [5:0]  trip_now;
    logic        trip_any;
    logic        timer_start;
    logic        timer_done;
    logic        cause_gone;
    logic        flag_cleared;
    logic        wr_setup;
    logic        wr_style;
    logic        wr_prop;
    logic        wr_flags;
    logic        in_fault;

    always_comb
    begin
        wr_setup = 1'b0;
        wr_style = 1'b0;
        wr_prop  = 1'b0;
        wr_flags = 1'b0;
        if (reg_wr && reg_addr == ADDR_SETUP_ONE)
            wr_setup = 1'b1;
        else if (reg_wr && reg_addr == ADDR_STYLE)
            wr_style = 1'b1;
        else if (reg_wr && reg_addr == ADDR_PROPAGATE)
            wr_prop = 1'b1;
        else if (reg_wr && reg_addr == ADDR_FLAGS)
            wr_flags = 1'b1;
    end

    // only tracking and phase voltage have enables; the rest are always armed
    always_comb
    begin
        enable_mask          = 6'h3F;
        enable_mask[FLT_TRK] = setup_reg[BIT_TRK_EN];
        enable_mask[FLT_PV]  = setup_reg[BIT_PV_EN];
    end

    assign trip_now     = (state_reg == PFL_ON) ? (fault_detect & enable_mask) : NO_FAULTS;
    assign trip_any     = trip_now != NO_FAULTS;
    assign timer_start  = clk_en && trip_any;
    assign cause_gone   = (fault_detect & cause_reg) == NO_FAULTS;
    assign flag_cleared = (flags_reg & cause_reg) == cause_reg;
    assign in_fault     = (state_reg == PFL_RETRY) || (state_reg == PFL_LATCHED);

    pfl_interval_timer #(
        .CYCLES (RESTART_CNT)
    ) u_timer (
        .clk    (clk),
        .rstn   (rstn),
        .clk_en (clk_en),
        .start  (timer_start),
        .done   (timer_done)
    );

    // configuration registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            setup_reg <= SETUP_RESET;
            style_reg <= STYLE_RESET;
            prop_reg  <= PROP_RESET;
        end
        else if (clk_en)
        begin
            if (wr_setup)
                setup_reg <= reg_wdata;
            if (wr_style)
                style_reg <= reg_wdata[5:0];
            if (wr_prop)
                prop_reg <= reg_wdata[5:0];
        end
    end

    // active-low flags; a trip in the clearing cycle still wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flags_reg <= FLAGS_RESET;
        else if (clk_en)
            flags_reg <= (flags_reg | (wr_flags ? reg_wdata[5:0] : NO_FAULTS)) & ~trip_now;
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PFL_OFF:
                if (turn_on_cmd)
                    state_next = PFL_ON;
            PFL_ON:
                if (trip_any)
                    state_next = ((trip_now & setup_reg[5:0]) != NO_FAULTS) ? PFL_LATCHED : PFL_RETRY;
                else if (!turn_on_cmd)
                    state_next = PFL_OFF;
            PFL_RETRY:
                // a persisting cause re-trips at once and re-arms the interval
                if (!turn_on_cmd)
                    state_next = PFL_OFF;
                else if (timer_done)
                    state_next = PFL_ON;
            PFL_LATCHED:
                if (timer_done && cause_gone && turn_on_cmd && (flag_cleared || cmd_low_seen_reg))
                    state_next = PFL_ON;
            default:
                state_next = PFL_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= PFL_OFF;
        else if (clk_en)
            state_reg <= state_next;
    end

    // remembers the cause and style of the last fault shutdown
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cause_reg        <= NO_FAULTS;
            active_style_reg <= STYLE_SEQ;
        end
        else if (clk_en && trip_any)
        begin
            cause_reg        <= trip_now;
            active_style_reg <= pick_style(trip_now, style_reg);
        end
    end

    // command toggle while latched counts as a clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cmd_low_seen_reg <= 1'b0;
        else if (clk_en)
        begin
            if (state_reg != PFL_LATCHED)
                cmd_low_seen_reg <= 1'b0;
            else if (!turn_on_cmd)
                cmd_low_seen_reg <= 1'b1;
        end
    end

    // power stage controls
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_enable   <= 1'b0;
            ramp_down_req <= 1'b0;
            hs_force_off  <= 1'b0;
            ls_force_off  <= 1'b0;
            ls_force_on   <= 1'b0;
            ok_pull_low   <= 1'b0;
        end
        else if (clk_en)
        begin
            conv_enable <= state_next == PFL_ON;
            if (state_next == PFL_RETRY || state_next == PFL_LATCHED)
            begin
                ramp_down_req <= pick_style(cause_next(), style_reg) == STYLE_SEQ;
                hs_force_off  <= pick_style(cause_next(), style_reg) != STYLE_SEQ;
                ls_force_off  <= pick_style(cause_next(), style_reg) == STYLE_CRIT;
                ls_force_on   <= pick_style(cause_next(), style_reg) == STYLE_EMERG;
                ok_pull_low   <= (cause_next() & prop_reg) != NO_FAULTS;
            end
            else
            begin
                ramp_down_req <= state_next == PFL_OFF; // commanded shutdown
                hs_force_off  <= 1'b0;
                ls_force_off  <= 1'b0;
                ls_force_on   <= 1'b0;
                ok_pull_low   <= 1'b0;
            end
        end
    end

    // cause in force after this edge
    function automatic logic [5:0] cause_next();
        cause_next = trip_any ? trip_now : cause_reg;
    endfunction

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_rd)
        begin
            if (reg_addr == ADDR_SETUP_ONE)
                reg_rdata <= setup_reg;
            else if (reg_addr == ADDR_STYLE)
                reg_rdata <= {2'h0, style_reg};
            else if (reg_addr == ADDR_PROPAGATE)
                reg_rdata <= {2'h0, prop_reg};
            else if (reg_addr == ADDR_FLAGS)
                reg_rdata <= {2'h0, flags_reg};
            else if (reg_addr == ADDR_STATE)
                reg_rdata <= {4'h0, timer_done, in_fault, state_reg};
            else
                reg_rdata <= 8'h00;
        end
    end

    assign fault_flag_register = flags_reg;

    a_latch_stays_off: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == PFL_LATCHED && !timer_done) |=> !conv_enable)
        else $error("latched converter turned on");
    a_retry_waits: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == PFL_RETRY && !timer_done && turn_on_cmd) |=> state_reg == PFL_RETRY)
        else $error("restart before interval");
    a_recover_cond: assert property (@(posedge clk) disable iff (!rstn)
        (state_reg == PFL_LATCHED) ##1 (state_reg == PFL_ON) |-> $past(timer_done) && $past(cause_gone))
        else $error("latched recovery without conditions");
    a_flag_drops: assert property (@(posedge clk) disable iff (!rstn)
        (clk_en && trip_any) |=> (flags_reg & cause_reg) == NO_FAULTS)
        else $error("fault flag not driven to zero");
    a_oc_critical: assert property (@(posedge clk) disable iff (!rstn)
        (clk_en && trip_now[FLT_OC]) |=> hs_force_off && (ls_force_off || ls_force_on))
        else $error("overcurrent not a fast turn-off");
    a_crit_both_off: assert property (@(posedge clk) disable iff (!rstn)
        ls_force_off |-> hs_force_off && !ls_force_on && !ramp_down_req)
        else $error("critical turn-off drive wrong");
    a_emerg_drive: assert property (@(posedge clk) disable iff (!rstn)
        ls_force_on |-> hs_force_off && !ls_force_off)
        else $error("emergency turn-off drive wrong");
    a_trk_gate: assert property (@(posedge clk) disable iff (!rstn)
        (clk_en && state_reg == PFL_ON && fault_detect[FLT_TRK] && setup_reg[BIT_TRK_EN]) |=> in_fault)
        else $error("enabled tracking fault did not trip");
    a_pv_gate: assert property (@(posedge clk) disable iff (!rstn)
        (clk_en && state_reg == PFL_ON && fault_detect[FLT_PV] && setup_reg[BIT_PV_EN]) |=> in_fault)
        else $error("enabled phase voltage fault did not trip");
    a_seq_ramp: assert property (@(posedge clk) disable iff (!rstn)
        (in_fault && active_style_reg == STYLE_SEQ) |-> ramp_down_req && !hs_force_off)
        else $error("sequenced turn-off not ramping");

    c_retry: cover property (@(posedge clk) disable iff (!rstn) state_reg == PFL_RETRY ##1 state_reg == PFL_ON);
    c_latch_recover: cover property (@(posedge clk) disable iff (!rstn)
        state_reg == PFL_LATCHED ##1 state_reg == PFL_ON);
    c_emergency: cover property (@(posedge clk) disable iff (!rstn) ls_force_on);
    c_clear_race: cover property (@(posedge clk) disable iff (!rstn) clk_en && wr_flags && trip_any);

endmodule

// [core/pfl_interval_timer.sv]
/*
 * One-shot interval timer for the restart and recovery wait.
 * Assumes start is a single-cycle pulse qualified by clk_en.
 */
`timescale 1ns/10ps
module pfl_interval_timer
    import pfl_pkg::*;
#(
    parameter int unsigned CYCLES = RESTART_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    input  wire logic start,
    output logic      done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] cnt_reg;
    logic          busy_reg;

    // restart reloads even mid-count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_reg  <= ZERO;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start)
            begin
                cnt_reg  <= LOAD;
                busy_reg <= 1'b1;
            end
            else if (busy_reg && cnt_reg != ZERO)
            begin
                cnt_reg <= cnt_reg - ONE;
            end
        end
    end

    // done holds until the next start
    assign done = busy_reg && (cnt_reg == ZERO);

    a_timer_rearm: assert property (@(posedge clk) disable iff (!rstn)
        (clk_en && start && CYCLES > 1) |=> !done)
        else $error("timer done right after start");

endmodule

// [core/pfl_pkg.sv]
/*
 * Constants, register map and state type for the point-of-load converter fault latch and turn-off controller.
 * Assumes a 125 MHz controller clock and a byte-wide register port.
 */
package pfl_pkg;

    // register addresses on the byte-wide register port
    localparam logic [7:0] ADDR_SETUP_ONE  = 8'h00;
    localparam logic [7:0] ADDR_STYLE      = 8'h01;
    localparam logic [7:0] ADDR_PROPAGATE  = 8'h02;
    localparam logic [7:0] ADDR_STATE      = 8'h03;
    localparam logic [7:0] ADDR_FLAGS      = 8'h16;

    // protection_setup_one fields
    localparam int unsigned BIT_TRK_EN   = 7;
    localparam int unsigned BIT_PV_EN    = 6;
    localparam int unsigned NUM_FAULTS   = 6;

    // fault positions, shared by latch selects, flags and propagation
    localparam int unsigned FLT_TRK = 5;
    localparam int unsigned FLT_OT  = 4;
    localparam int unsigned FLT_OC  = 3;
    localparam int unsigned FLT_UV  = 2;
    localparam int unsigned FLT_OV  = 1;
    localparam int unsigned FLT_PV  = 0;

    // turn-off style codes and field positions in the style register
    localparam logic [1:0] STYLE_SEQ   = 2'h0;
    localparam logic [1:0] STYLE_CRIT  = 2'h1;
    localparam logic [1:0] STYLE_EMERG = 2'h2;
    localparam int unsigned STY_OT_LSB = 0;
    localparam int unsigned STY_UV_LSB = 2;
    localparam int unsigned STY_OV_LSB = 4;

    // reset values
    localparam logic [7:0] SETUP_RESET = 8'h43;
    localparam logic [5:0] STYLE_RESET = 6'h20;
    localparam logic [5:0] PROP_RESET  = 6'h3F;
    localparam logic [5:0] FLAGS_RESET = 6'h3F;
    localparam logic [5:0] NO_FAULTS   = 6'h00;

    // restart and recovery interval
    localparam int unsigned RESTART_TIME_US = 130000;
    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned RESTART_CYCLES  = RESTART_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        PFL_OFF,
        PFL_ON,
        PFL_RETRY,
        PFL_LATCHED
    } pfl_state_e;

endpackage

// [tb/pfl_host_model.sv]
/*
 * Register host model: drives single-byte write and read strobes on the controller's register port.
 * Assumes clk is shared with the bench and that wr and rd are called only after reset is released.
 */
`timescale 1ns/10ps
module pfl_host_model
(
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // idle bus shows inverted values, so a stale address never passes for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        v        = reg_rdata;
    endtask
endmodule

// [tb/pol_fault_latch_turnoff_tb_top.sv]
/*
 * Self-checking bench for the fault latch and turn-off controller.
 * Assumes pfl_pkg and the host model are compiled first; the restart interval is shortened.
 */
`timescale 1ns/10ps
module pol_fault_latch_turnoff_tb_top
    import pfl_pkg::*;
;
    localparam int R     = 20;
    localparam int LIMIT = 3000;
    localparam logic [7:0] PROP_W = 8'h15;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       clk_en = 1'b1;
    logic       turn_on_cmd = 1'b0;
    logic [5:0] fault_detect = 6'h00;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       conv_enable;
    logic       ramp_down_req;
    logic       hs_force_off;
    logic       ls_force_off;
    logic       ls_force_on;
    logic       ok_pull_low;
    logic [5:0] fault_flag_register;
    logic [7:0] d;
    int         n;
    int         fail_count = 0;
    int         n_compared = 0;
    int         cycles = 0;

    pfl_fault_ctrl #(.RESTART_CNT(R)) pfl_fault_ctrl_i (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .turn_on_cmd(turn_on_cmd), .fault_detect(fault_detect),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_enable(conv_enable), .ramp_down_req(ramp_down_req), .hs_force_off(hs_force_off),
        .ls_force_off(ls_force_off), .ls_force_on(ls_force_on), .ok_pull_low(ok_pull_low),
        .fault_flag_register(fault_flag_register));

    pfl_host_model pfl_host_model_i (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    always #4 clk = ~clk;

    task test_done();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard: every scenario is bounded, so this only trips on a stuck design
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            fail_count++;
            $display("timeout after %0d cycles", cycles);
            test_done();
        end
    end

    task chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task chk_bit(input string nm, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // n = cycles until conv_enable equals v, or mx+1 if it never does
    task wait_en(input logic v, input int mx);
        n = mx + 1;
        for (int i = 1; i <= mx; i++)
        begin
            @(posedge clk);
            #1;
            if (conv_enable === v)
            begin
                n = i;
                break;
            end
        end
    endtask

    task power_up();
        turn_on_cmd = 1'b1;
        wait_en(1'b1, 10);
        chk_bit("converter on", 1'b1, conv_enable);
    endtask

    task trip(input int idx);
        @(posedge clk);
        #1;
        fault_detect[idx] = 1'b1;
        wait_en(1'b0, 4);
        chk_bit("converter tripped", 1'b0, conv_enable);
    endtask

    task t_regs();
        pfl_host_model_i.rd(ADDR_SETUP_ONE, d);
        chk_byte("setup reset", 8'h43, d);
        pfl_host_model_i.rd(ADDR_FLAGS, d);
        chk_byte("flags reset", 8'h3F, d);
        pfl_host_model_i.rd(8'h55, d);
        chk_byte("unmapped read", 8'h00, d);
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'hBC);
        pfl_host_model_i.rd(ADDR_SETUP_ONE, d);
        chk_byte("setup write", 8'hBC, d);
        pfl_host_model_i.wr(ADDR_PROPAGATE, PROP_W);
        pfl_host_model_i.rd(ADDR_PROPAGATE, d);
        chk_byte("propagate write", PROP_W, d);
        // a write while the enable is low must leave the register alone
        clk_en = 1'b0;
        pfl_host_model_i.wr(ADDR_PROPAGATE, 8'h2A);
        clk_en = 1'b1;
        pfl_host_model_i.rd(ADDR_PROPAGATE, d);
        chk_byte("frozen write ignored", PROP_W, d);
    endtask

    task t_retry();
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h40);
        power_up();
        trip(FLT_OC);
        chk_bit("oc high side off", 1'b1, hs_force_off);
        chk_bit("oc low side off", 1'b1, ls_force_off);
        chk_bit("oc low side on", 1'b0, ls_force_on);
        chk_byte("flag port", 8'h37, {2'h0, fault_flag_register});
        wait_en(1'b1, R + 10);
        chk_bit("first retry period", 1'b1, n >= R - 2 && n <= R + 4);
        wait_en(1'b0, 4);
        chk_bit("retry re-trips", 1'b0, conv_enable);
        fault_detect[FLT_OC] = 1'b0;
        wait_en(1'b1, R + 10);
        chk_bit("second retry period", 1'b1, n >= R - 2 && n <= R + 4);
        wait_en(1'b0, 30);
        chk_bit("stays on once clear", 1'b1, n == 31);
        pfl_host_model_i.rd(ADDR_FLAGS, d);
        chk_byte("oc flag held low", 8'h37, d);
        pfl_host_model_i.wr(ADDR_FLAGS, 8'h3F);
    endtask

    task t_latch();
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h44);
        trip(FLT_UV);
        fault_detect[FLT_UV] = 1'b0;
        pfl_host_model_i.wr(ADDR_FLAGS, 8'h3F);
        wait_en(1'b1, R - 6);
        chk_bit("no restart before interval", 1'b1, n == R - 5);
        wait_en(1'b1, 12);
        chk_bit("restart after flag clear", 1'b1, conv_enable);
        trip(FLT_UV);
        fault_detect[FLT_UV] = 1'b0;
        wait_en(1'b1, 2 * R);
        chk_bit("latched stays off", 1'b1, n == 2 * R + 1);
        pfl_host_model_i.rd(ADDR_STATE, d);
        chk_byte("latched state", 8'h03, d & 8'h03);
        turn_on_cmd = 1'b0;
        @(posedge clk);
        #1;
        turn_on_cmd = 1'b1;
        wait_en(1'b1, 10);
        chk_bit("restart after toggle", 1'b1, conv_enable);
        pfl_host_model_i.wr(ADDR_FLAGS, 8'h3F);
    endtask

    task t_styles();
        int idx_tab[3];
        int lsb_tab[3];
        logic [1:0] st_tab[4];
        idx_tab = '{FLT_OT, FLT_UV, FLT_OV};
        lsb_tab = '{STY_OT_LSB, STY_UV_LSB, STY_OV_LSB};
        // code 3 is not a style of its own and must act as sequenced
        st_tab = '{STYLE_SEQ, STYLE_CRIT, STYLE_EMERG, 2'h3};
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h40);
        for (int f = 0; f < 3; f++)
        begin
            for (int s = 0; s < 4; s++)
            begin
                pfl_host_model_i.wr(ADDR_STYLE, 8'(st_tab[s]) << lsb_tab[f]);
                power_up();
                trip(idx_tab[f]);
                @(posedge clk);
                #1;
                chk_bit("high side off", s == 1 || s == 2, hs_force_off);
                chk_bit("low side off", s == 1, ls_force_off);
                chk_bit("low side on", s == 2, ls_force_on);
                if (s == 0 || s == 3)
                    chk_bit("ramp down", 1'b1, ramp_down_req);
                chk_bit("propagation", PROP_W[idx_tab[f]], ok_pull_low);
                fault_detect = 6'h00;
                wait_en(1'b1, R + 10);
                chk_bit("style restart", 1'b1, conv_enable);
                pfl_host_model_i.wr(ADDR_FLAGS, 8'h3F);
            end
        end
    endtask

    task t_enables();
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h00);
        power_up();
        fault_detect = 6'h21;
        wait_en(1'b0, 6);
        chk_bit("disabled faults ignored", 1'b1, n == 7);
        fault_detect = 6'h00;
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h80);
        trip(FLT_TRK);
        chk_bit("trk high side off", 1'b1, hs_force_off);
        chk_bit("trk low side off", 1'b1, ls_force_off);
        fault_detect = 6'h00;
        wait_en(1'b1, R + 10);
        chk_bit("trk restart", 1'b1, conv_enable);
        pfl_host_model_i.wr(ADDR_SETUP_ONE, 8'h40);
        trip(FLT_PV);
        chk_bit("pv high side off", 1'b1, hs_force_off);
        chk_bit("pv low side off", 1'b1, ls_force_off);
        fault_detect = 6'h00;
        wait_en(1'b1, R + 10);
        chk_bit("pv restart", 1'b1, conv_enable);
        pfl_host_model_i.wr(ADDR_FLAGS, 8'h3F);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_regs();
        t_retry();
        t_latch();
        t_styles();
        t_enables();
        test_done();
    end
endmodule
